// File: oscillator_status_and_events_test.sv
// self-checking bench of the oscillator status and clock event block
// assumes the oscillator model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module oscillator_status_and_events_test;
   import ose_pkg::*;
   typedef struct packed {logic [3:0] on; logic [4:0] evt; logic [31:0] rdy; logic [31:0] ev;} ose_row_t;
   logic clk, reset_n, reg_write, reg_read, clock_irq;
   logic [31:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] on, running, stable;
   logic [4:0] evt, line;
   int fails = 0;
   int checks = 0;
   ose_row_t rows [10] = '{'{4'h1, 5'h00, 32'h1, 32'h0}, '{4'h2, 5'h00, 32'h2, 32'h0},
      '{4'h4, 5'h00, 32'h4, 32'h0}, '{4'h8, 5'h00, 32'h8, 32'h0}, '{4'hF, 5'h01, 32'hF, 32'h01},
      '{4'hF, 5'h02, 32'hF, 32'h02}, '{4'hF, 5'h04, 32'hF, 32'h04}, '{4'hF, 5'h08, 32'hF, 32'h08},
      '{4'hF, 5'h10, 32'hF, 32'h10}, '{4'h0, 5'h00, 32'h0, 32'h0}};
   ose_osc_model model_u (.clk(clk), .reset_n(reset_n), .osc_on(on), .evt_req(evt),
      .osc_running(running), .osc_stable(stable), .evt_line(line));
   ose_osc_status dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_running(running),
      .osc_stable(stable), .clock_loss(line[0]), .fast_rc_trim_missed(line[1]),
      .slow_rc_trim_missed(line[2]), .fast_rc_trim_updated(line[3]),
      .slow_rc_trim_updated(line[4]), .clock_irq(clock_irq));
   // ----------------------------------------------------------------
   // bus, wait and check tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // sampled a moment after the edge so the registered irq has landed
   task automatic irq_is(input logic e);
      #1;
      chk({31'h0, clock_irq}, {31'h0, e});
   endtask
   task automatic tally_and_finish;
      $display("fails=%0d checks=%0d", fails, checks);
      if (fails == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      {reset_n, reg_write, reg_read, reg_addr, reg_wdata, on, evt} = '0;
      cyc(2);
      reset_n <= 1'b1;
      rd(OSE_ADDR_READY, 32'h0);
      rd(OSE_ADDR_EVENT, 32'h0);
      irq_is(1'b0);
      foreach (rows[i]) begin
         on <= rows[i].on;
         evt <= rows[i].evt;
         cyc(8);
         evt <= 5'h00;
         cyc(44);
         rd(OSE_ADDR_READY, rows[i].rdy);
         rd(OSE_ADDR_EVENT, rows[i].ev);
         irq_is(rows[i].ev != 32'h0);
         wr(OSE_ADDR_EVENT, rows[i].ev);
         rd(OSE_ADDR_EVENT, 32'h0);
      end
      on <= 4'h4;
      cyc(12);
      rd(OSE_ADDR_READY, 32'h0);
      cyc(40);
      wr(OSE_ADDR_READY, 32'hFFFFFFFF);
      rd(OSE_ADDR_READY, 32'h4);
      rd(32'h40300040, 32'h0);
      evt <= 5'h06;
      cyc(8);
      evt <= 5'h00;
      cyc(8);
      wr(OSE_ADDR_EVENT, 32'h2);
      rd(OSE_ADDR_EVENT, 32'h4);
      evt <= 5'h01;
      cyc(10);
      wr(OSE_ADDR_EVENT, 32'h5);
      rd(OSE_ADDR_EVENT, 32'h1);
      evt <= 5'h08;
      cyc(8);
      evt <= 5'h00;
      cyc(8);
      wr(OSE_ADDR_EVENT, 32'h1);
      wr(OSE_ADDR_MASK, 32'h0);
      cyc(2);
      irq_is(1'b0);
      rd(OSE_ADDR_EVENT, 32'h8);
      rd(OSE_ADDR_MASK, 32'h0);
      rd(OSE_ADDR_PEND, 32'h0);
      wr(OSE_ADDR_MASK, 32'h1F);
      cyc(2);
      irq_is(1'b1);
      rd(OSE_ADDR_PEND, 32'h8);
      // clearing every flag at once must drop the request two edges later
      wr(OSE_ADDR_EVENT, 32'h1F);
      cyc(2);
      irq_is(1'b0);
      rd(OSE_ADDR_EVENT, 32'h0);
      evt <= 5'h10;
      cyc(8);
      evt <= 5'h00;
      cyc(8);
      reset_n <= 1'b0;
      cyc(2);
      reset_n <= 1'b1;
      rd(OSE_ADDR_EVENT, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// File: ose_chk.sv
// port checker of the oscillator status and clock event block
// assumes the mask stays enabled whenever a new event arrives
`timescale 1ns/1ps
`default_nettype none
module ose_chk
   import ose_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   // far side
   input wire logic [3:0] osc_running,
   input wire logic [3:0] osc_stable,
   input wire logic fast_rc_trim_missed,
   input wire logic slow_rc_trim_missed,
   input wire logic fast_rc_trim_updated,
   input wire logic slow_rc_trim_updated,
   input wire logic clock_loss,
   input wire logic clock_irq
);
   logic [3:0] rdy_w, lvl_q, st_q, st_d, qt_q, qt_d;
   logic trim_w;
   assign rdy_w = osc_running & osc_stable;
   assign trim_w = fast_rc_trim_missed | slow_rc_trim_missed | fast_rc_trim_updated
      | slow_rc_trim_updated;
   // saturating counts: 8 quiet cycles cover the synchroniser delay
   always_comb begin
      st_d = (rdy_w != lvl_q) ? 4'h0 : ((st_q == 4'h8) ? st_q : st_q + 4'h1);
      qt_d = (trim_w | clock_loss) ? 4'h0 : ((qt_q == 4'h8) ? qt_q : qt_q + 4'h1);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lvl_q <= 4'h0;
         st_q <= 4'h0;
         qt_q <= 4'h0;
      end else begin
         lvl_q <= rdy_w;
         st_q <= st_d;
         qt_q <= qt_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_ready_level: assert property (reg_read && reg_addr == OSE_ADDR_READY && st_q == 4'h8
      |=> reg_rdata == {28'h0000000, $past(lvl_q)}) else $error("ready flags wrong");
   chk_event_upper: assert property (reg_read && reg_addr == OSE_ADDR_EVENT
      |=> reg_rdata[31:5] == 27'h0) else $error("event upper bits set");
   chk_loss_irq: assert property ($rose(clock_loss) |-> ##[3:8] clock_irq)
      else $error("no irq after clock loss");
   chk_trim_irq: assert property ($rose(trim_w) |-> ##[3:8] clock_irq)
      else $error("no irq after trim event");
   chk_loss_hold: assert property (clock_loss [*8] |-> clock_irq)
      else $error("irq low during clock loss");
   chk_loss_sticky: assert property (clock_loss [*8] ##1 (reg_read && reg_addr == OSE_ADDR_EVENT)
      |=> reg_rdata[0]) else $error("loss bit not shown");
   chk_clear_all: assert property (reg_write && reg_addr == OSE_ADDR_EVENT
      && reg_wdata[4:0] == 5'h1F && qt_q == 4'h8 |-> ##2 !clock_irq) else $error("clear failed");
   chk_irq_fall: assert property ($fell(clock_irq) |-> $past(reg_write) || $past(reg_write, 2))
      else $error("irq fell without write");
   cover property (reg_read && reg_addr == OSE_ADDR_READY && lvl_q == 4'hF);
   cover property (clock_irq ##1 !clock_irq);
   cover property (clock_loss [*8]);
endmodule
bind ose_osc_status ose_chk chk_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .osc_running(osc_running), .osc_stable(osc_stable), .clock_loss(clock_loss),
   .fast_rc_trim_missed(fast_rc_trim_missed), .slow_rc_trim_missed(slow_rc_trim_missed),
   .fast_rc_trim_updated(fast_rc_trim_updated), .slow_rc_trim_updated(slow_rc_trim_updated),
   .clock_irq(clock_irq));
`default_nettype wire

// File: ose_osc_model.sv
// oscillators, calibration engines and clock monitor seen by the block
// assumes the bench holds each event request for several cycles
`timescale 1ns/1ps
`default_nettype none
module ose_osc_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bench commands
   input wire logic [3:0] osc_on,
   input wire logic [4:0] evt_req,
   // lines into the block, events in event bit order
   output logic [3:0] osc_running,
   output logic [3:0] osc_stable,
   output logic [4:0] evt_line
);
   logic [4:0] cnt_q [2];
   logic [4:0] cnt_d [2];
   // crystals need 31 cycles of start-up before they report stable
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cnt_d[i] = !osc_on[i+2] ? 5'h00 : ((cnt_q[i] == 5'h1F) ? cnt_q[i] : cnt_q[i] + 5'h01);
      end
   end
   assign osc_stable = osc_running & {cnt_q[1] == 5'h1F, cnt_q[0] == 5'h1F, 2'h3};
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_running <= 4'h0;
         evt_line <= 5'h00;
         cnt_q <= '{5'h00, 5'h00};
      end else begin
         osc_running <= osc_on;
         evt_line <= evt_req;
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// File: ose_osc_status.sv
// oscillator ready flags, sticky clock events and interrupt request
// assumes oscillator and calibration signals arrive asynchronously
//
// How it works
// - slow crystal ready only while running and stable
// - fast crystal ready only while running and stable
// - slow rc ready only while running and stable
// - fast rc ready only while running and stable
// - crystal enable alone never raises ready
// - ready flags read-only, writes ignored
// - event flags register feeds the interrupt
// - writing one clears that event flag only
// - slow rc trim update sets bit four
// - fast rc trim update sets bit three
// - slow rc trim miss sets bit two
// - fast rc trim miss sets bit one
// - clock loss indication sets sticky bit zero
`timescale 1ns/1ps
`default_nettype none
module ose_osc_status
   import ose_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // oscillator state, one bit per oscillator
   input wire logic [3:0] osc_running,
   input wire logic [3:0] osc_stable,
   // calibration events, held or pulsed by the engines
   input wire logic fast_rc_trim_missed,
   input wire logic slow_rc_trim_missed,
   input wire logic fast_rc_trim_updated,
   input wire logic slow_rc_trim_updated,
   // clock monitor
   input wire logic clock_loss,
   // interrupt request
   output logic clock_irq
);

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   ose_sync_if #(.WIDTH(OSE_SYN_W)) syn_if ();

   assign syn_if.raw = {clock_loss,
                        slow_rc_trim_updated,
                        fast_rc_trim_updated,
                        slow_rc_trim_missed,
                        fast_rc_trim_missed,
                        osc_stable,
                        osc_running};

   ose_sync #(
      .WIDTH(OSE_SYN_W)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .port_io(syn_if)
   );

   logic [3:0] run_s;
   logic [3:0] stb_s;
   logic [3:0] cal_rise_s;
   logic loss_s;

   assign run_s = syn_if.level[OSE_SYN_RUN +: OSE_NUM_OSC];
   assign stb_s = syn_if.level[OSE_SYN_STB +: OSE_NUM_OSC];
   assign cal_rise_s = syn_if.rise[OSE_SYN_EVT +: 4];
   assign loss_s = syn_if.level[OSE_SYN_LOSS];

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic hit_ready;
   logic hit_event;
   logic hit_mask;
   logic hit_pend;
   logic wr_event;
   logic wr_mask;

   always_comb begin
      hit_ready = (reg_addr == OSE_ADDR_READY);
      hit_event = (reg_addr == OSE_ADDR_EVENT);
      hit_mask = (reg_addr == OSE_ADDR_MASK);
      hit_pend = (reg_addr == OSE_ADDR_PEND);
      // the ready and pending words take no write at all
      wr_event = reg_write & hit_event;
      wr_mask = reg_write & hit_mask;
   end

   // ----------------------------------------------------------------
   // oscillator ready flags
   // ----------------------------------------------------------------
   logic [3:0] ready_q;
   logic [3:0] ready_d;

   // enable alone is not enough: a crystal still in start-up is not stable
   always_comb begin
      ready_d = ready_q;
      ready_d[OSE_RDY_SLOW_XTAL] = run_s[OSE_RDY_SLOW_XTAL] & stb_s[OSE_RDY_SLOW_XTAL];
      ready_d[OSE_RDY_FAST_XTAL] = run_s[OSE_RDY_FAST_XTAL] & stb_s[OSE_RDY_FAST_XTAL];
      ready_d[OSE_RDY_SLOW_RC] = run_s[OSE_RDY_SLOW_RC] & stb_s[OSE_RDY_SLOW_RC];
      ready_d[OSE_RDY_FAST_RC] = run_s[OSE_RDY_FAST_RC] & stb_s[OSE_RDY_FAST_RC];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_q <= OSE_READY_RST;
      end else begin
         ready_q <= ready_d;
      end
   end

   // ----------------------------------------------------------------
   // event sources
   // ----------------------------------------------------------------
   logic [4:0] evt_set;

   always_comb begin
      evt_set = '0;
      evt_set[OSE_EVT_SLOW_UPD] = cal_rise_s[3];
      evt_set[OSE_EVT_FAST_UPD] = cal_rise_s[2];
      evt_set[OSE_EVT_SLOW_MISS] = cal_rise_s[1];
      evt_set[OSE_EVT_FAST_MISS] = cal_rise_s[0];
      // a level: the flag cannot be cleared while the loss persists
      evt_set[OSE_EVT_CLK_LOSS] = loss_s;
   end

   // ----------------------------------------------------------------
   // sticky event flags
   // ----------------------------------------------------------------
   logic [4:0] event_q;
   logic [4:0] event_d;
   logic [4:0] evt_clr;

   always_comb begin
      evt_clr = '0;
      if (wr_event) begin
         evt_clr = reg_wdata[OSE_NUM_EVT-1:0];
      end
      // set is applied after clear so a same-cycle event survives
      event_d = (event_q & ~evt_clr) | evt_set;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         event_q <= OSE_EVENT_RST;
      end else begin
         event_q <= event_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupt mask
   // ----------------------------------------------------------------
   logic [4:0] mask_q;
   logic [4:0] mask_d;

   // all sources enabled out of reset, so any flag interrupts by default
   always_comb begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = reg_wdata[OSE_NUM_EVT-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= OSE_MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupt request
   // ----------------------------------------------------------------
   logic irq_q;
   logic irq_d;
   logic [4:0] pend;

   // registered output costs one cycle of latency after the flag
   always_comb begin
      pend = event_q & mask_q;
      irq_d = |pend;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign clock_irq = irq_q;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // data stand one cycle only; unmapped or idle reads give zero
   always_comb begin
      rdata_d = OSE_RDATA_RST;
      if (reg_read) begin
         if (hit_ready) begin
            rdata_d[OSE_NUM_OSC-1:0] = ready_q;
         end else if (hit_event) begin
            rdata_d[OSE_NUM_EVT-1:0] = event_q;
         end else if (hit_mask) begin
            rdata_d[OSE_NUM_EVT-1:0] = mask_q;
         end else if (hit_pend) begin
            rdata_d[OSE_NUM_EVT-1:0] = pend;
         end else begin
            rdata_d = OSE_RDATA_RST;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= OSE_RDATA_RST;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// File: ose_pkg.sv
// constants of the oscillator status and clock event block
// assumes a byte-addressed 32-bit register port supplied by the system bus
package ose_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] OSE_ADDR_READY = 32'h40300044;
   localparam logic [31:0] OSE_ADDR_EVENT = 32'h40300048;
   localparam logic [31:0] OSE_ADDR_MASK = 32'h4030004C;
   localparam logic [31:0] OSE_ADDR_PEND = 32'h40300050;

   // ----------------------------------------------------------------
   // field widths and positions
   // ----------------------------------------------------------------
   localparam int OSE_NUM_OSC = 4;
   localparam int OSE_NUM_EVT = 5;
   localparam int OSE_RDY_FAST_RC = 0;
   localparam int OSE_RDY_SLOW_RC = 1;
   localparam int OSE_RDY_FAST_XTAL = 2;
   localparam int OSE_RDY_SLOW_XTAL = 3;
   localparam int OSE_EVT_CLK_LOSS = 0;
   localparam int OSE_EVT_FAST_MISS = 1;
   localparam int OSE_EVT_SLOW_MISS = 2;
   localparam int OSE_EVT_FAST_UPD = 3;
   localparam int OSE_EVT_SLOW_UPD = 4;

   // ----------------------------------------------------------------
   // synchroniser vector layout
   // ----------------------------------------------------------------
   localparam int OSE_SYN_RUN = 0;
   localparam int OSE_SYN_STB = 4;
   localparam int OSE_SYN_EVT = 8;
   localparam int OSE_SYN_LOSS = 12;
   localparam int OSE_SYN_W = 13;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] OSE_READY_RST = 4'h0;
   localparam logic [4:0] OSE_EVENT_RST = 5'h00;
   localparam logic [4:0] OSE_MASK_RST = 5'h1F;
   localparam logic [31:0] OSE_RDATA_RST = 32'h00000000;

endpackage

// File: ose_sync.sv
// three-stage input synchroniser with agreement filter and rise pulse
// assumes inputs come from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ose_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bundle
   ose_sync_if.sync port_io
);

   // ----------------------------------------------------------------
   // stages
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] ff1_q;
   logic [WIDTH-1:0] ff2_q;
   logic [WIDTH-1:0] ff3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;
   logic [WIDTH-1:0] rise_q;
   logic [WIDTH-1:0] rise_d;

   // a rise counts only once stages two and three agree; any disagreement clears the level
   always_comb begin
      level_d = (level_q & ~(ff2_q ^ ff3_q)) | (ff3_q & ~(ff2_q ^ ff3_q));
      rise_d = level_d & ~level_q;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ff1_q <= '0;
         ff2_q <= '0;
         ff3_q <= '0;
         level_q <= '0;
         rise_q <= '0;
      end else begin
         ff1_q <= port_io.raw;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         level_q <= level_d;
         rise_q <= rise_d;
      end
   end

   assign port_io.level = level_q;
   assign port_io.rise = rise_q;

endmodule
`default_nettype wire

// File: ose_sync_if.sv
// bundle between the top and its input synchroniser
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ose_sync_if #(
   parameter int WIDTH = 1
);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] level;
   logic [WIDTH-1:0] rise;

   modport sync (input raw, output level, output rise);
   modport user (output raw, input level, input rise);
endinterface
`default_nettype wire
